// ==== include/fcsd_params.svh ====
// Constants for the flash command sequence driver: codes, addresses, timing
`ifndef FCSD_PARAMS_SVH
`define FCSD_PARAMS_SVH

// Clock rate and time unit conversion
`define FCSD_CLK_MHZ      125
`define FCSD_NS_PER_US    1000
// Least time in ns rounded up to whole clocks, never below one
`define FCSD_CYC(ns) ((((ns) * `FCSD_CLK_MHZ + `FCSD_NS_PER_US - 1) \
	/ `FCSD_NS_PER_US) < 1 ? 1 : (((ns) * `FCSD_CLK_MHZ \
	+ `FCSD_NS_PER_US - 1) / `FCSD_NS_PER_US))

// Strobe timing in ns (address/data setup, strobe low, strobe high, access)
`define FCSD_TSETUP_NS    20
`define FCSD_TWP_NS       40
`define FCSD_TWPH_NS      30
`define FCSD_TACC_NS      100

// Command cycle addresses, low eleven bits matter, rest driven low
`define FCSD_A_UNLOCK1    21'h0_0555
`define FCSD_A_UNLOCK2    21'h0_02AA
`define FCSD_A_CFI_SHORT  21'h0_0055
`define FCSD_A_ANY        21'h0_0000

// Command data words, upper byte driven low
`define FCSD_D_UNLOCK1    16'h00AA
`define FCSD_D_UNLOCK2    16'h0055
`define FCSD_D_PROGRAM    16'h00A0
`define FCSD_D_ERASE_SET  16'h0080
`define FCSD_D_SECID_QRY  16'h0088
`define FCSD_D_SECID_PRG  16'h00A5
`define FCSD_D_LOCKOUT    16'h0085
`define FCSD_D_PRODID     16'h0090
`define FCSD_D_CFI        16'h0098
`define FCSD_D_EXIT       16'h00F0
`define FCSD_D_SECTOR     16'h0050
`define FCSD_D_BLOCK      16'h0030
`define FCSD_D_CHIP       16'h0010
`define FCSD_D_SUSPEND    16'h00B0
`define FCSD_D_RESUME     16'h0030
`define FCSD_D_ZERO       16'h0000

// Sector and block address fields, last valid security-ID word
`define FCSD_SECTOR_LSB   11
`define FCSD_BLOCK_LSB    15
`define FCSD_SECID_LAST   21'h0_0087

// Write counts per sequence and phase timer width
`define FCSD_N_LONG       3'h6
`define FCSD_N_FOUR       3'h4
`define FCSD_N_THREE      3'h3
`define FCSD_N_ONE        3'h1
`define FCSD_CNT_W        8

`endif

// ==== include/fcsd_pkg.sv ====
// Types shared by the flash command sequence driver and its bench
`default_nettype none
package fcsd_pkg;

	// Operations the user may request
	typedef enum logic [3:0] {
		FCSD_OP_READ      = 4'h0,
		FCSD_OP_PROGRAM   = 4'h1,
		FCSD_OP_SECT_ERA  = 4'h2,
		FCSD_OP_BLK_ERA   = 4'h3,
		FCSD_OP_CHIP_ERA  = 4'h4,
		FCSD_OP_SUSPEND   = 4'h5,
		FCSD_OP_RESUME    = 4'h6,
		FCSD_OP_SECID_QRY = 4'h7,
		FCSD_OP_SECID_PRG = 4'h8,
		FCSD_OP_LOCKOUT   = 4'h9,
		FCSD_OP_PRODID    = 4'hA,
		FCSD_OP_CFI_LONG  = 4'hB,
		FCSD_OP_CFI_SHORT = 4'hC,
		FCSD_OP_EXIT_LONG = 4'hD,
		FCSD_OP_EXIT_SHRT = 4'hE
	} fcsd_op_t;

	// One user request
	typedef struct packed {
		fcsd_op_t    op;
		logic [20:0] addr;
		logic [15:0] data;
	} fcsd_req_t;

	// One bus write of a sequence
	typedef struct packed {
		logic [20:0] addr;
		logic [15:0] data;
	} fcsd_step_t;

	// Flash pin outputs; dq_oe_n low while driving the data bus
	typedef struct packed {
		logic        ce_n;
		logic        oe_n;
		logic        we_n;
		logic [20:0] addr;
		logic [15:0] dq;
		logic        dq_oe_n;
	} fcsd_bus_t;

endpackage
`default_nettype wire

// ==== src/fcsd_host.sv ====
// Host controller that drives flash command sequences and reads
`include "fcsd_params.svh"
`default_nettype none

// What this block does
// - Every multi-write sequence opens with two unlock writes
// - Third write at 555H carries command code
// - Program fourth write gives address and word
// - Erase repeats unlock pair as writes four, five
// - Sixth write picks sector, block or chip
// - Security program only inside valid word range
// - Lock-out is 85H then 0000H anywhere
// - Suspend, resume, short CFI single writes
module fcsd_host #(
	parameter int TSETUP_CYC = `FCSD_CYC(`FCSD_TSETUP_NS),
	parameter int TWP_CYC    = `FCSD_CYC(`FCSD_TWP_NS),
	parameter int TWPH_CYC   = `FCSD_CYC(`FCSD_TWPH_NS),
	parameter int TACC_CYC   = `FCSD_CYC(`FCSD_TACC_NS)
) (
	input  wire logic              core_clk_i,  // System clock
	input  wire logic              rst_n_i,     // Sync reset, low
	input  wire logic              req_valid_i, // Request offered
	input  wire fcsd_pkg::fcsd_req_t req_i,     // Request contents
	output logic                   req_ready_o, // Idle, takes request
	output logic                   done_o,      // Request finished
	output logic                   err_o,       // Request refused
	output logic [15:0]            rdata_o,     // Read result
	output fcsd_pkg::fcsd_bus_t    bus_o,       // Flash pins out
	input  wire logic [15:0]       dq_i         // Flash data pins in
);
	import fcsd_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Types, constants, state
	// Sequencer states
	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_SETUP = 5'b00010,
		ST_WLOW  = 5'b00100,
		ST_WHIGH = 5'b01000,
		ST_READ  = 5'b10000
	} fcsd_state_t;

	localparam int CW = `FCSD_CNT_W;
	localparam logic [CW-1:0] SETUP_LD = CW'(TSETUP_CYC - 1);
	localparam logic [CW-1:0] WP_LD    = CW'(TWP_CYC - 1);
	localparam logic [CW-1:0] WPH_LD   = CW'(TWPH_CYC - 1);
	localparam logic [CW-1:0] ACC_LD   = CW'(TACC_CYC - 1);

	fcsd_state_t     state_q;     // Sequencer state
	fcsd_req_t       req_q;       // Latched request
	logic [2:0]      idx_q;       // Current write index
	logic [CW-1:0]   cnt_q;       // Phase timer
	fcsd_bus_t       bus_q;       // Registered pins
	logic            ready_q;     // Idle flag
	logic            done_q;      // Finish pulse
	logic            err_q;       // Refusal pulse
	logic [15:0]     rdata_q;     // Read capture
	logic [15:0]     dq_s1_q;     // Sync stage one
	logic [15:0]     dq_s2_q;     // Sync stage two
	logic [15:0]     dq_s3_q;     // Sync stage three
	fcsd_step_t      step_d;      // Next write to issue
	logic [2:0]      nxt_idx;     // Index after current
	logic            last_wr;     // Current write ends sequence
	logic            secid_bad;   // Security address outside range

	////////////////////////////////////////////////////////////////////////
	// Sequence tables
	// Number of bus writes per operation
	function automatic logic [2:0] n_writes(fcsd_op_t op);
		case (op)
			FCSD_OP_SECT_ERA, FCSD_OP_BLK_ERA,
			FCSD_OP_CHIP_ERA:  n_writes = `FCSD_N_LONG;
			FCSD_OP_PROGRAM, FCSD_OP_SECID_PRG,
			FCSD_OP_LOCKOUT:   n_writes = `FCSD_N_FOUR;
			FCSD_OP_SUSPEND, FCSD_OP_RESUME, FCSD_OP_CFI_SHORT,
			FCSD_OP_EXIT_SHRT: n_writes = `FCSD_N_ONE;
			default:           n_writes = `FCSD_N_THREE;
		endcase
	endfunction

	// Command code of the third write
	function automatic logic [15:0] code_of(fcsd_op_t op);
		case (op)
			FCSD_OP_PROGRAM:   code_of = `FCSD_D_PROGRAM;
			FCSD_OP_SECID_QRY: code_of = `FCSD_D_SECID_QRY;
			FCSD_OP_SECID_PRG: code_of = `FCSD_D_SECID_PRG;
			FCSD_OP_LOCKOUT:   code_of = `FCSD_D_LOCKOUT;
			FCSD_OP_PRODID:    code_of = `FCSD_D_PRODID;
			FCSD_OP_CFI_LONG:  code_of = `FCSD_D_CFI;
			FCSD_OP_EXIT_LONG: code_of = `FCSD_D_EXIT;
			default:           code_of = `FCSD_D_ERASE_SET;
		endcase
	endfunction

	// Address and data of write number idx
	function automatic fcsd_step_t step_of(fcsd_req_t r, logic [2:0] idx);
		fcsd_step_t s;
		s = '{`FCSD_A_UNLOCK1, `FCSD_D_UNLOCK1};
		case (r.op)
			// Single-write commands, address mostly free
			FCSD_OP_SUSPEND:   s = '{`FCSD_A_ANY, `FCSD_D_SUSPEND};
			FCSD_OP_RESUME:    s = '{`FCSD_A_ANY, `FCSD_D_RESUME};
			FCSD_OP_CFI_SHORT: s = '{`FCSD_A_CFI_SHORT, `FCSD_D_CFI};
			FCSD_OP_EXIT_SHRT: s = '{`FCSD_A_ANY, `FCSD_D_EXIT};
			default: begin
				case (idx)
					// Second unlock word, also fifth for erase
					3'h1, 3'h4:
						s = '{`FCSD_A_UNLOCK2, `FCSD_D_UNLOCK2};
					// Command code at 555H
					3'h2: s.data = code_of(r.op);
					// Program target, lock-out zero, or erase re-unlock
					3'h3: begin
						if (r.op == FCSD_OP_PROGRAM ||
						    r.op == FCSD_OP_SECID_PRG) begin
							s.addr = r.addr;
							s.data = r.data;
						end else if (r.op == FCSD_OP_LOCKOUT) begin
							s.addr = r.addr;
							s.data = `FCSD_D_ZERO;
						end
					end
					// Erase type selection
					3'h5: begin
						if (r.op == FCSD_OP_SECT_ERA) begin
							s.addr = {r.addr[20:`FCSD_SECTOR_LSB],
							          `FCSD_SECTOR_LSB'(0)};
							s.data = `FCSD_D_SECTOR;
						end else if (r.op == FCSD_OP_BLK_ERA) begin
							s.addr = {r.addr[20:`FCSD_BLOCK_LSB],
							          `FCSD_BLOCK_LSB'(0)};
							s.data = `FCSD_D_BLOCK;
						end else begin
							s.data = `FCSD_D_CHIP;
						end
					end
					// First unlock word; erase fourth write keeps it via index three
					default: s = '{`FCSD_A_UNLOCK1, `FCSD_D_UNLOCK1};
				endcase
			end
		endcase
		step_of = s;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Combinational helpers
	// Next write, end of sequence, range check
	always_comb begin
		nxt_idx   = idx_q + 3'h1;
		last_wr   = (nxt_idx == n_writes(req_q.op));
		step_d    = step_of(req_q, nxt_idx);
		secid_bad = (req_i.op == FCSD_OP_SECID_PRG) &&
		            (req_i.addr > `FCSD_SECID_LAST);
	end

	////////////////////////////////////////////////////////////////////////
	// Data pin synchroniser
	// Three stages; second and third must agree before use
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			dq_s1_q <= 16'h0000;
			dq_s2_q <= 16'h0000;
			dq_s3_q <= 16'h0000;
		end else begin
			dq_s1_q <= dq_i;
			dq_s2_q <= dq_s1_q;
			dq_s3_q <= dq_s2_q;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sequencer
	// Bus cycle state machine and pin drive
	always_ff @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			state_q <= ST_IDLE;
			req_q   <= '0;
			idx_q   <= 3'h0;
			cnt_q   <= '0;
			bus_q   <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
			             addr: 21'h0_0000, dq: 16'h0000, dq_oe_n: 1'b1};
			ready_q <= 1'b0;
			done_q  <= 1'b0;
			err_q   <= 1'b0;
			rdata_q <= 16'h0000;
		end else begin
			done_q <= 1'b0;
			err_q  <= 1'b0;
			case (state_q)
				// Wait for a request
				ST_IDLE: begin
					ready_q <= 1'b1;
					if (req_valid_i && ready_q) begin
						ready_q <= 1'b0;
						if (secid_bad) begin
							// Out-of-range target refused on the spot
							done_q  <= 1'b1;
							err_q   <= 1'b1;
							ready_q <= 1'b1;
						end else if (req_i.op == FCSD_OP_READ) begin
							req_q      <= req_i;
							bus_q.addr <= req_i.addr;
							bus_q.ce_n <= 1'b0;
							bus_q.oe_n <= 1'b0;
							cnt_q      <= ACC_LD;
							state_q    <= ST_READ;
						end else begin
							req_q         <= req_i;
							idx_q         <= 3'h0;
							bus_q.addr    <= step_of(req_i, 3'h0).addr;
							bus_q.dq      <= step_of(req_i, 3'h0).data;
							bus_q.dq_oe_n <= 1'b0;
							bus_q.ce_n    <= 1'b0;
							bus_q.oe_n    <= 1'b1;
							cnt_q         <= SETUP_LD;
							state_q       <= ST_SETUP;
						end
					end
				end
				// Address and data settle before the strobe
				ST_SETUP: begin
					if (cnt_q != '0) begin
						cnt_q <= cnt_q - CW'(1);
					end else begin
						bus_q.we_n <= 1'b0;
						cnt_q      <= WP_LD;
						state_q    <= ST_WLOW;
					end
				end
				// Strobe low; rising edge latches the write
				ST_WLOW: begin
					if (cnt_q != '0) begin
						cnt_q <= cnt_q - CW'(1);
					end else begin
						bus_q.we_n <= 1'b1;
						cnt_q      <= WPH_LD;
						state_q    <= ST_WHIGH;
					end
				end
				// Strobe high recovery, then next write or finish
				ST_WHIGH: begin
					if (cnt_q != '0) begin
						cnt_q <= cnt_q - CW'(1);
					end else if (last_wr) begin
						bus_q.ce_n    <= 1'b1;
						bus_q.dq_oe_n <= 1'b1;
						done_q        <= 1'b1;
						ready_q       <= 1'b1;
						state_q       <= ST_IDLE;
					end else begin
						idx_q      <= nxt_idx;
						bus_q.addr <= step_d.addr;
						bus_q.dq   <= step_d.data;
						cnt_q      <= SETUP_LD;
						state_q    <= ST_SETUP;
					end
				end
				// Read access, capture once synchronised data is steady
				ST_READ: begin
					if (cnt_q != '0) begin
						cnt_q <= cnt_q - CW'(1);
					end else if (dq_s2_q == dq_s3_q) begin
						rdata_q    <= dq_s3_q;
						bus_q.ce_n <= 1'b1;
						bus_q.oe_n <= 1'b1;
						done_q     <= 1'b1;
						ready_q    <= 1'b1;
						state_q    <= ST_IDLE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs, all from flip-flops
	assign req_ready_o = ready_q;
	assign done_o      = done_q;
	assign err_o       = err_q;
	assign rdata_o     = rdata_q;
	assign bus_o       = bus_q;

endmodule
`default_nettype wire

// ==== test/fcsd_flash_model.sv ====
// Behavioural flash device on the far side of the driver
`default_nettype none
module fcsd_flash #(
	parameter logic [15:0] MAKER_ID = 16'h00C3, // Arbitrary value
	parameter logic [15:0] DEV_ID   = 16'h7A11, // Arbitrary value
	parameter int          BUSY_NS  = 200       // Internal operation time
) (
	input  wire fcsd_pkg::fcsd_bus_t bus_i, // Pins from host
	output logic [15:0]              dq_o   // Data pins to host
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam int SEC = 32'h0100_0000; // Security key offset
	realtime     busy_until = 0; // End of internal program or erase
	logic [36:0] wq[$];    // Log of latched writes
	logic [15:0] mem[int]; // Cells, absent ones erased
	int          st;       // Sequence step
	int          md = 0;   // Read mode, normal at power-up
	logic [7:0]  cmd;      // Held command code
	logic        lock = 0; // User segment locked
	logic [10:0] a;        // Compared address bits
	logic [7:0]  d;        // Compared data byte
	initial st = 0;
	initial dq_o = 16'h0000;

	// Cell read, erased if never programmed
	function automatic logic [15:0] rdm(input int k);
		return mem.exists(k) ? mem[k] : 16'hFFFF;
	endfunction
	// Read map by mode
	function automatic logic [15:0] rdv(input logic [20:0] k);
		if (md == 1) return k[0] ? DEV_ID : MAKER_ID;
		if (md == 2 && k[7:0] == 8'hFF) return {12'h000, !lock, 3'h0};
		if (md == 2) return rdm(int'(k) + SEC);
		return rdm(int'(k));
	endfunction

	////////////////////////////////////////////////////////////////////
	// Command decode on strobe release while selected
	always @(posedge bus_i.we_n) begin
		if (!bus_i.ce_n && bus_i.oe_n) begin
			wq.push_back({bus_i.addr, bus_i.dq});
			a = bus_i.addr[10:0];
			d = bus_i.dq[7:0];
			if (st == 0 && d == 8'hF0 && $realtime >= busy_until) md = 0;
			if (st == 0 && a == 11'h055 && d == 8'h98) md = 3;
			case (st)
			0: st = (a == 11'h555 && d == 8'hAA) ? 1 : 0;
			1: st = (a == 11'h2AA && d == 8'h55) ? 2 : 0;
			2: begin
				cmd = d;
				st = d inside {8'hA0, 8'hA5, 8'h85} ? 3 : d == 8'h80 ? 4 : 0;
				if (d == 8'h90) md = 1;
				if (d == 8'h88) md = 2;
				if (d == 8'h98) md = 3;
				if (d == 8'hF0 && $realtime >= busy_until) md = 0;
			end
			3: begin
				if (cmd == 8'hA0) mem[bus_i.addr] = rdm(bus_i.addr) & bus_i.dq;
				if (cmd == 8'hA0) busy_until = $realtime + BUSY_NS;
				if (cmd == 8'hA5 && !lock && bus_i.addr <= 21'h0_0087)
					mem[bus_i.addr + SEC] = rdm(bus_i.addr + SEC) & bus_i.dq;
				if (cmd == 8'h85 && bus_i.dq == 16'h0000) lock = 1'b1;
				st = 0;
			end
			4: st = (a == 11'h555 && d == 8'hAA) ? 5 : 0;
			5: st = (a == 11'h2AA && d == 8'h55) ? 6 : 0;
			default: begin // erase contents not modelled
				busy_until = $realtime + BUSY_NS;
				st = 0;
			end
			endcase
		end
	end
	// Answer reads, else a changing pattern
	always @(bus_i) begin
		if (!bus_i.ce_n && !bus_i.oe_n) dq_o = rdv(bus_i.addr);
		else dq_o = ~dq_o;
	end
endmodule
`default_nettype wire

// ==== test/fcsd_host_asserts.sv ====
// Port checks for the flash command sequence driver
`default_nettype none
module fcsd_chk (
	input wire logic                core_clk_i,  // Clock
	input wire logic                rst_n_i,     // Sync reset, low
	input wire logic                req_valid_i, // Request offered
	input wire fcsd_pkg::fcsd_req_t req_i,       // Request
	input wire logic                req_ready_o, // Idle
	input wire logic                done_o,      // Finished
	input wire logic                err_o,       // Refused
	input wire logic [15:0]         rdata_o,     // Read data
	input wire fcsd_pkg::fcsd_bus_t bus_o,       // Flash pins
	input wire logic [15:0]         dq_i         // Flash data in
);
	timeunit 1ns;
	timeprecision 100ps;
	import fcsd_pkg::*;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!rst_n_i);

	////////////////////////////////////////////////////////////////////
	// Write strobe only as a selected, driven write
	property p_strobe;
		!bus_o.we_n |-> !bus_o.ce_n && bus_o.oe_n && !bus_o.dq_oe_n;
	endproperty
	a_strobe: assert property (p_strobe)
		else $error("write strobe outside a write");
	// Address and data held across the latching edge
	property p_latch;
		$rose(bus_o.we_n) |-> $stable(bus_o.addr) && $stable(bus_o.dq);
	endproperty
	a_latch: assert property (p_latch)
		else $error("bus moved at strobe release");
	// Strobe low for exactly five cycles
	property p_pulse;
		$fell(bus_o.we_n) |-> !bus_o.we_n [*5] ##1 bus_o.we_n;
	endproperty
	a_pulse: assert property (p_pulse)
		else $error("strobe width wrong");
	// First write of a burst: unlock word only at its address
	property p_first;
		$fell(bus_o.ce_n) && bus_o.oe_n |->
			((bus_o.dq == 16'h00AA) == (bus_o.addr == 21'h0_0555));
	endproperty
	a_first: assert property (p_first)
		else $error("opening write mismatched");
	// Refusal flag only with completion
	property p_err;
		err_o |-> done_o;
	endproperty
	a_err: assert property (p_err)
		else $error("refusal without completion");
	// Out-of-range security program refused next cycle, bus idle
	property p_refuse;
		req_valid_i && req_ready_o && req_i.op == FCSD_OP_SECID_PRG
			&& req_i.addr > 21'h0_0087 |=> done_o && err_o && bus_o.ce_n;
	endproperty
	a_refuse: assert property (p_refuse)
		else $error("bad security address not refused");
	// Ready drops after a request is taken, or done rises in the next cycle
	property p_take;
		req_valid_i && req_ready_o |=> !req_ready_o || done_o;
	endproperty
	a_take: assert property (p_take)
		else $error("ready stayed after take");
	// Reads never overlap a write or a driven bus
	property p_read;
		!bus_o.oe_n |-> bus_o.we_n && bus_o.dq_oe_n;
	endproperty
	a_read: assert property (p_read)
		else $error("read overlaps write");
endmodule

bind fcsd_host fcsd_chk u_chk (
	.core_clk_i (core_clk_i), .rst_n_i (rst_n_i),
	.req_valid_i(req_valid_i), .req_i (req_i),
	.req_ready_o(req_ready_o), .done_o (done_o), .err_o (err_o),
	.rdata_o (rdata_o), .bus_o (bus_o), .dq_i (dq_i)
);
`default_nettype wire

// ==== test/fcsd_host_tb.sv ====
// Self-checking bench for the flash command sequence driver
`default_nettype none
module fcsd_host_tb
	import fcsd_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [15:0] MK = 16'h00C3; // Arbitrary value
	localparam logic [15:0] DV = 16'h7A11; // Arbitrary value
	localparam logic [36:0] U1 = {21'h0_0555, 16'h00AA}; // Unlock one
	localparam logic [36:0] U2 = {21'h0_02AA, 16'h0055}; // Unlock two
	localparam logic [7:0] CODE [16] = '{8'h00, 8'hA0, 8'h80, 8'h80,
		8'h80, 8'h00, 8'h00, 8'h88, 8'hA5, 8'h85, 8'h90, 8'h98, 8'h00,
		8'hF0, 8'h00, 8'h00}; // Third-write code by operation
	logic        clk = 0;         // Clock
	logic        rst_n = 0;       // Reset
	logic        vld = 0;         // Request valid
	fcsd_req_t   req = '0;        // Request
	logic        rdy, done, err;  // Handshake
	logic [15:0] rdata, dq;       // Read data, flash data
	fcsd_bus_t   bus;             // Flash pins
	int          fails = 0;       // Mismatches
	int          samples_checked = 0; // Comparisons
	int          cyc = 0;         // Cycle count
	logic [31:0] rs = 32'hed49;   // Random state
	logic [36:0] eq[$];           // Expected writes

	fcsd_host uut (.core_clk_i(clk), .rst_n_i(rst_n), .req_valid_i(vld),
		.req_i(req), .req_ready_o(rdy), .done_o(done), .err_o(err),
		.rdata_o(rdata), .bus_o(bus), .dq_i(dq));
	fcsd_flash #(.MAKER_ID(MK), .DEV_ID(DV)) u_flash (.bus_i(bus),
		.dq_o(dq));

	////////////////////////////////////////////////////////////////////
	always #4 clk = ~clk;
	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			fails++;
			final_report();
		end
	end

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		return s ^ (s << 5);
	endfunction
	task automatic chk(input string n, input logic [36:0] s, e);
		samples_checked++;
		if (s !== e) begin
			fails++;
			$display("[ERR] %s exp %h got %h", n, e, s);
		end
	endtask
	// Writes a request should put on the bus
	task automatic expw(input fcsd_op_t op, input logic [20:0] a,
		input logic [15:0] d);
		eq.delete();
		case (op)
		FCSD_OP_READ: ;
		FCSD_OP_SUSPEND: eq.push_back({21'h0_0000, 16'h00B0});
		FCSD_OP_RESUME: eq.push_back({21'h0_0000, 16'h0030});
		FCSD_OP_CFI_SHORT: eq.push_back({21'h0_0055, 16'h0098});
		FCSD_OP_EXIT_SHRT: eq.push_back({21'h0_0000, 16'h00F0});
		default: begin
			eq = '{U1, U2, {21'h0_0555, 8'h00, CODE[op]}};
			if (op inside {FCSD_OP_PROGRAM, FCSD_OP_SECID_PRG})
				eq.push_back({a, d});
			if (op == FCSD_OP_LOCKOUT) eq.push_back({a, 16'h0000});
			if (CODE[op] == 8'h80) eq = {eq, U1, U2};
			if (op == FCSD_OP_SECT_ERA)
				eq.push_back({a[20:11], 11'h000, 16'h0050});
			if (op == FCSD_OP_BLK_ERA)
				eq.push_back({a[20:15], 15'h0000, 16'h0030});
			if (op == FCSD_OP_CHIP_ERA)
				eq.push_back({21'h0_0555, 16'h0010});
		end
		endcase
	endtask
	// One request, then compare completion and bus writes
	task automatic go(input fcsd_op_t op, input logic [20:0] a,
		input logic [15:0] d);
		int i;
		logic e;
		// Let one edge pass, so vld never toggles twice in one step
		@(posedge clk) #2;
		e = (op == FCSD_OP_SECID_PRG) && (a > 21'h0_0087);
		expw(op, a, d);
		if (e) eq.delete();
		for (i = 0; i < 50 && rdy !== 1'b1; i++) @(posedge clk) #2;
		u_flash.wq.delete();
		req = '{op, a, d};
		vld = 1'b1;
		@(posedge clk) #2;
		vld = 1'b0;
		for (i = 0; i < 500 && done !== 1'b1; i++) @(posedge clk) #2;
		chk("done", done, 1'b1);
		chk("err", err, e);
		chk("nwr", 37'(u_flash.wq.size()), 37'(eq.size()));
		foreach (eq[j]) chk("wr", u_flash.wq[j], eq[j]);
	endtask
	task automatic rd(input logic [20:0] a, input logic [15:0] e, m);
		go(FCSD_OP_READ, a, 16'h0000);
		chk("rdata", rdata & m, e & m);
	endtask
	task automatic final_report();
		if (fails == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////
	initial begin
		int i;
		logic [20:0] a;
		repeat (20) @(posedge clk) #2;
		chk("rdy_rst", rdy, 1'b0);
		rst_n = 1'b1;
		// Security segment: lock state, program, lock-out
		go(FCSD_OP_SECID_QRY, 21'h0_0000, 16'h0000);
		rd(21'h0_00FF, 16'h0008, 16'h0008);
		rs = xs(rs);
		a = 21'(rs[15:0] % 136);
		go(FCSD_OP_SECID_PRG, a, rs[31:16]);
		rd(a, rs[31:16], 16'hFFFF);
		go(FCSD_OP_SECID_PRG, a, rs[15:0]);
		rd(a, rs[31:16] & rs[15:0], 16'hFFFF);
		go(FCSD_OP_LOCKOUT, rs[20:0], 16'h0000);
		rd(21'h0_00FF, 16'h0000, 16'h0008);
		go(FCSD_OP_SECID_PRG, a, 16'h0000);
		rd(a, rs[31:16] & rs[15:0], 16'hFFFF);
		go(FCSD_OP_EXIT_SHRT, 21'h0_0000, 16'h0000);
		go(FCSD_OP_SECID_PRG, 21'h0_0088, rs[15:0]);
		// Every operation except read with random operands
		for (i = 1; i < 15; i++) begin
			rs = xs(rs);
			go(fcsd_op_t'(i), rs[20:0], rs[31:16]);
		end
		go(FCSD_OP_PRODID, 21'h0_0000, 16'h0000);
		rd(21'h0_0000, MK, 16'hFFFF);
		rd(21'h0_0001, DV, 16'hFFFF);
		go(FCSD_OP_EXIT_LONG, 21'h0_0000, 16'h0000);
		// Program then read back in normal mode
		repeat (8) begin
			rs = xs(rs);
			go(FCSD_OP_PROGRAM, rs[20:0], rs[31:16]);
			rd(rs[20:0], rs[31:16], 16'hFFFF);
		end
		final_report();
	end
endmodule
`default_nettype wire
